/* File: src/charge_time_unit_defines.vh */
// register map, field positions, reset values and source codes of the charge time unit
`ifndef CHARGE_TIME_UNIT_DEFINES_VH
`define CHARGE_TIME_UNIT_DEFINES_VH

// ********************************************************************
// register addresses
// ********************************************************************
`define CHARGE_TIME_UNIT_ADDR_W          2
`define CHARGE_TIME_UNIT_ADDR_CTRL       2'h0
`define CHARGE_TIME_UNIT_ADDR_EDGE       2'h1
`define CHARGE_TIME_UNIT_ADDR_CURR       2'h2

// ********************************************************************
// control register one fields
// ********************************************************************
`define CHARGE_TIME_UNIT_CTRL_EN         15
`define CHARGE_TIME_UNIT_CTRL_SIDL       13
`define CHARGE_TIME_UNIT_CTRL_DELAY_GENERATION_ENABLE       12
`define CHARGE_TIME_UNIT_CTRL_HWEDGE     11
`define CHARGE_TIME_UNIT_CTRL_ORDER      10
`define CHARGE_TIME_UNIT_CTRL_DISCH      9
`define CHARGE_TIME_UNIT_CTRL_TRIG       8
`define CHARGE_TIME_UNIT_CTRL_MASK       16'hbf00

// ********************************************************************
// edge config and flags fields
// ********************************************************************
`define CHARGE_TIME_UNIT_E1_MOD          15
`define CHARGE_TIME_UNIT_E1_POL          14
`define CHARGE_TIME_UNIT_E1_SEL_HI       13
`define CHARGE_TIME_UNIT_E1_SEL_LO       10
`define CHARGE_TIME_UNIT_E2_FLAG         9
`define CHARGE_TIME_UNIT_E1_FLAG         8
`define CHARGE_TIME_UNIT_E2_MOD          7
`define CHARGE_TIME_UNIT_E2_POL          6
`define CHARGE_TIME_UNIT_E2_SEL_HI       5
`define CHARGE_TIME_UNIT_E2_SEL_LO       2
`define CHARGE_TIME_UNIT_EDGE_MASK       16'hfffc

// ********************************************************************
// current source fields
// ********************************************************************
`define CHARGE_TIME_UNIT_TRIM_HI         15
`define CHARGE_TIME_UNIT_TRIM_LO         10
`define CHARGE_TIME_UNIT_RNG_HI          9
`define CHARGE_TIME_UNIT_RNG_LO          8
`define CHARGE_TIME_UNIT_CURR_MASK       16'hff00

`define CHARGE_TIME_UNIT_RESET_VAL       16'h0000

// ********************************************************************
// edge source codes
// ********************************************************************
`define CHARGE_TIME_UNIT_E1_SRC_TMR      4'h0
`define CHARGE_TIME_UNIT_E1_SRC_CMP      4'h1
`define CHARGE_TIME_UNIT_E1_SRC_PIN2     4'h2
`define CHARGE_TIME_UNIT_E1_SRC_PIN1     4'h3
`define CHARGE_TIME_UNIT_E2_SRC_CAP      4'h0
`define CHARGE_TIME_UNIT_E2_SRC_CMP      4'h1
`define CHARGE_TIME_UNIT_E2_SRC_PIN1     4'h2
`define CHARGE_TIME_UNIT_E2_SRC_PIN2     4'h3
`define CHARGE_TIME_UNIT_E2_SRC_CMPR     4'h4

`endif

/* File: src/charge_time_unit_edge_det.v */
// one edge channel detector: polarity and edge or level sensitivity
`timescale 1ns/100ps
`include "charge_time_unit_defines.vh"

module ctec_edge_det (
	input  wire       mclk_i,
	input  wire       reset_i,
	input  wire       run_i,
	input  wire       src_i,
	input  wire       src_ok_i,
	input  wire       edge_mode_i,
	input  wire       pol_i,
	output wire       hit_o
);

	reg   prev_q;
	wire  act;

	// polarity folded in so both modes look for an active high level
	assign act = pol_i ? src_i : ~src_i;

	always @(posedge mclk_i) begin
		if (reset_i)
			prev_q <= 1'b1;
		else
			prev_q <= run_i ? act : 1'b1;
	end

	// prev forced high while stopped so re-enabling never fakes an edge
	assign hit_o = run_i & src_ok_i & act & (edge_mode_i ? ~prev_q : 1'b1);

endmodule // ctec_edge_det

/* File: src/charge_time_unit_top.v */
// charge time unit digital control: registers, edge channels, trigger and analog controls
//
// Design decisions made here: strobed register access and the placing of the registers.
`timescale 1ns/100ps
`include "charge_time_unit_defines.vh"

// Overview of operation
// [R1] unit works only while unit_enable is one; else everything idle. Here current_trim and current_range outputs still follow the register.
// [R2] halt_in_idle set stops the unit while the device is in idle.
// [R3] delay_generation_enable turns edge delay generation on or off.
// [R4] hardware_edge_enable selects hardware sources; otherwise software writes the flags.
// [R5] edge_order_enable lets edge two be accepted only after edge one.
// [R6] source_discharge grounds the analog current source output while set.
// [R7] converter_trigger_enable lets the unit issue start of conversion.
// [R8] software discharges converter capacitor first and keeps converter sampling meanwhile.
// [R9] first_edge_sensitivity: one edge sensitive, zero level sensitive.
// [R10] first_edge_polarity: one positive response, zero negative response.
// [R11] first_edge_source: timer, compare, pin two, pin one; rest reserved.
// [R12] second_edge_flag reads one after edge two; software may write it.
// [R13] first_edge_flag reads one after edge one; software may write it.
// [R14] second_edge_sensitivity: one edge sensitive, zero level sensitive.
// [R15] second_edge_polarity: one positive response, zero negative response.
// [R16] second_edge_source: capture, compare, pin one, pin two, comparator.
// [R17] current_trim is a signed six bit two percent step trim code.
// [R18] current_range picks base, ten, hundred or thousand times current.
// [R19] software avoids the thousand times range with the temperature diode.
// [R20] hardware sets each flag on its qualified event; flag holds until cleared.
// [R21] unimplemented bits read zero and ignore writes.
module ctec_top (
	input  wire                     mclk_i,
	input  wire                     reset_i,
	input  wire [`CHARGE_TIME_UNIT_ADDR_W-1:0]  addr_i,
	input  wire [15:0]              wdata_i,
	input  wire                     wr_i,
	input  wire                     rd_i,
	output reg  [15:0]              rdata_o,
	input  wire                     idle_i,
	input  wire                     timer_one_i,
	input  wire                     compare_unit_one_i,
	input  wire                     capture_unit_one_i,
	input  wire                     comparator_one_i,
	input  wire                     edge_pin_one_i,
	input  wire                     edge_pin_two_i,
	output reg                      source_on_o,
	output reg                      source_discharge_o,
	output reg                      converter_trigger_o,
	output reg                      delay_pulse_o,
	output reg  [5:0]               current_trim_o,
	output reg  [1:0]               current_range_o
);

	// ********************************************************************
	// registers
	// ********************************************************************
	reg  [15:0]  ctrl_q;
	reg  [15:0]  edge_q;
	reg  [15:0]  curr_q;
	reg  [15:0]  ctrl_d;
	reg  [15:0]  edge_d;
	reg  [15:0]  curr_d;

	wire         run;
	wire         hw_edges;
	wire         hit1;
	wire         hit2;
	wire         ok1;
	wire         ok2;
	wire         src1;
	wire         src2;
	wire         set1;
	wire         set2;
	wire         both_now;
	reg          both_q;

	// source multiplexer for edge one
	function sel1;
		input [3:0] code;
		input       tmr, cmp, p1, p2;
		begin
			case (code)
				`CHARGE_TIME_UNIT_E1_SRC_TMR:  sel1 = tmr;
				`CHARGE_TIME_UNIT_E1_SRC_CMP:  sel1 = cmp;
				`CHARGE_TIME_UNIT_E1_SRC_PIN2: sel1 = p2;
				`CHARGE_TIME_UNIT_E1_SRC_PIN1: sel1 = p1;
				default:           sel1 = 1'b0;
			endcase
		end
	endfunction

	// source multiplexer for edge two
	function sel2;
		input [3:0] code;
		input       cap, cmp, p1, p2, cmpr;
		begin
			case (code)
				`CHARGE_TIME_UNIT_E2_SRC_CAP:  sel2 = cap;
				`CHARGE_TIME_UNIT_E2_SRC_CMP:  sel2 = cmp;
				`CHARGE_TIME_UNIT_E2_SRC_PIN1: sel2 = p1;
				`CHARGE_TIME_UNIT_E2_SRC_PIN2: sel2 = p2;
				`CHARGE_TIME_UNIT_E2_SRC_CMPR: sel2 = cmpr;
				default:           sel2 = 1'b0;
			endcase
		end
	endfunction

	// ********************************************************************
	// run qualification
	// ********************************************************************
	assign run      = ctrl_q[`CHARGE_TIME_UNIT_CTRL_EN] & ~(ctrl_q[`CHARGE_TIME_UNIT_CTRL_SIDL] & idle_i); // [R1] [R2]
	assign hw_edges = run & ctrl_q[`CHARGE_TIME_UNIT_CTRL_HWEDGE]; // [R4]

	assign src1 = sel1(edge_q[`CHARGE_TIME_UNIT_E1_SEL_HI:`CHARGE_TIME_UNIT_E1_SEL_LO], timer_one_i, compare_unit_one_i,
		edge_pin_one_i, edge_pin_two_i); // [R11]
	assign src2 = sel2(edge_q[`CHARGE_TIME_UNIT_E2_SEL_HI:`CHARGE_TIME_UNIT_E2_SEL_LO], capture_unit_one_i, compare_unit_one_i,
		edge_pin_one_i, edge_pin_two_i, comparator_one_i); // [R16]

	// reserved codes never produce an event
	assign ok1 = (edge_q[`CHARGE_TIME_UNIT_E1_SEL_HI:`CHARGE_TIME_UNIT_E1_SEL_LO] <= `CHARGE_TIME_UNIT_E1_SRC_PIN1);
	assign ok2 = (edge_q[`CHARGE_TIME_UNIT_E2_SEL_HI:`CHARGE_TIME_UNIT_E2_SEL_LO] <= `CHARGE_TIME_UNIT_E2_SRC_CMPR);

	// ********************************************************************
	// edge channels
	// ********************************************************************
	ctec_edge_det u_edge1 (
		.mclk_i      (mclk_i),
		.reset_i     (reset_i),
		.run_i       (hw_edges),
		.src_i       (src1),
		.src_ok_i    (ok1),
		.edge_mode_i (edge_q[`CHARGE_TIME_UNIT_E1_MOD]), // [R9]
		.pol_i       (edge_q[`CHARGE_TIME_UNIT_E1_POL]), // [R10]
		.hit_o       (hit1)
	);

	ctec_edge_det u_edge2 (
		.mclk_i      (mclk_i),
		.reset_i     (reset_i),
		.run_i       (hw_edges),
		.src_i       (src2),
		.src_ok_i    (ok2),
		.edge_mode_i (edge_q[`CHARGE_TIME_UNIT_E2_MOD]), // [R14]
		.pol_i       (edge_q[`CHARGE_TIME_UNIT_E2_POL]), // [R15]
		.hit_o       (hit2)
	);

	assign set1 = hit1; // [R20]
	// with ordering, edge two counts only once edge one is already flagged
	assign set2 = hit2 & (~ctrl_q[`CHARGE_TIME_UNIT_CTRL_ORDER] | edge_q[`CHARGE_TIME_UNIT_E1_FLAG]); // [R5] [R20]

	// ********************************************************************
	// register write path
	// ********************************************************************
	always @* begin
		ctrl_d = ctrl_q;
		edge_d = edge_q;
		curr_d = curr_q;
		if (wr_i) begin
			case (addr_i)
				`CHARGE_TIME_UNIT_ADDR_CTRL: begin
					ctrl_d = wdata_i & `CHARGE_TIME_UNIT_CTRL_MASK; // [R21]
				end
				`CHARGE_TIME_UNIT_ADDR_EDGE: begin
					edge_d = wdata_i & `CHARGE_TIME_UNIT_EDGE_MASK; // [R21] [R12] [R13]
				end
				`CHARGE_TIME_UNIT_ADDR_CURR: begin
					curr_d = wdata_i & `CHARGE_TIME_UNIT_CURR_MASK; // [R21]
				end
				default: begin
					ctrl_d = ctrl_q;
				end
			endcase
		end
		// hardware set wins over a software clear in the same cycle
		if (set1)
			edge_d[`CHARGE_TIME_UNIT_E1_FLAG] = 1'b1; // [R13] [R20]
		if (set2)
			edge_d[`CHARGE_TIME_UNIT_E2_FLAG] = 1'b1; // [R12] [R20]
	end

	always @(posedge mclk_i) begin
		if (reset_i) begin
			ctrl_q <= `CHARGE_TIME_UNIT_RESET_VAL;
			edge_q <= `CHARGE_TIME_UNIT_RESET_VAL;
			curr_q <= `CHARGE_TIME_UNIT_RESET_VAL;
		end else begin
			ctrl_q <= ctrl_d;
			edge_q <= edge_d;
			curr_q <= curr_d;
		end
	end

	// ********************************************************************
	// read path
	// ********************************************************************
	always @(posedge mclk_i) begin
		if (reset_i)
			rdata_o <= 16'h0000;
		else if (rd_i) begin
			case (addr_i)
				`CHARGE_TIME_UNIT_ADDR_CTRL: rdata_o <= ctrl_q;
				`CHARGE_TIME_UNIT_ADDR_EDGE: rdata_o <= edge_q;
				`CHARGE_TIME_UNIT_ADDR_CURR: rdata_o <= curr_q;
				default:         rdata_o <= 16'h0000;
			endcase
		end else
			rdata_o <= 16'h0000;
	end

	// ********************************************************************
	// analog and converter controls
	// ********************************************************************
	// source charges between edge one and edge two; both flags set means done
	assign both_now = edge_q[`CHARGE_TIME_UNIT_E1_FLAG] & edge_q[`CHARGE_TIME_UNIT_E2_FLAG];

	always @(posedge mclk_i) begin
		if (reset_i) begin
			both_q              <= 1'b0;
			source_on_o         <= 1'b0;
			source_discharge_o  <= 1'b0;
			converter_trigger_o <= 1'b0;
			delay_pulse_o       <= 1'b0;
			current_trim_o      <= 6'h00;
			current_range_o     <= 2'h0;
		end else begin
			both_q              <= run & both_now;
			source_on_o         <= run & (edge_q[`CHARGE_TIME_UNIT_E1_FLAG] ^ edge_q[`CHARGE_TIME_UNIT_E2_FLAG]);
			source_discharge_o  <= run & ctrl_q[`CHARGE_TIME_UNIT_CTRL_DISCH]; // [R6]
			// one pulse per completed edge pair; limitation: needs flags cleared to rearm
			converter_trigger_o <= run & ctrl_q[`CHARGE_TIME_UNIT_CTRL_TRIG] & both_now & ~both_q; // [R7]
			// delay output high from edge one until edge two
			delay_pulse_o       <= run & ctrl_q[`CHARGE_TIME_UNIT_CTRL_DELAY_GENERATION_ENABLE] & edge_q[`CHARGE_TIME_UNIT_E1_FLAG]
				& ~edge_q[`CHARGE_TIME_UNIT_E2_FLAG]; // [R3]
			current_trim_o      <= curr_q[`CHARGE_TIME_UNIT_TRIM_HI:`CHARGE_TIME_UNIT_TRIM_LO]; // [R17]
			current_range_o     <= curr_q[`CHARGE_TIME_UNIT_RNG_HI:`CHARGE_TIME_UNIT_RNG_LO]; // [R18]
		end
	end

endmodule // ctec_top

/* File: verif/ctec_src_model.sv */
// far side model: levels of the six edge sources seen by the unit
`timescale 1ns/100ps
module ctec_src_model (
	input  wire       mclk_i,
	input  wire [5:0] want_i,
	output reg  [5:0] lvl_o
);
	// levels move just after the edge, as the on-chip source modules do
	initial lvl_o = 6'h00;
	always @(posedge mclk_i) begin
		lvl_o <= want_i;
	end
endmodule // ctec_src_model

/* File: verif/ctec_chk.sv */
// port checker of the charge time unit
`timescale 1ns/100ps
`include "charge_time_unit_defines.vh"
module ctec_chk (
	input wire                   mclk_i,
	input wire                   reset_i,
	input wire [`CHARGE_TIME_UNIT_ADDR_W-1:0] addr_i,
	input wire [15:0]            wdata_i,
	input wire                   wr_i,
	input wire                   rd_i,
	input wire [15:0]            rdata_o,
	input wire                   idle_i,
	input wire                   source_on_o,
	input wire                   source_discharge_o,
	input wire                   converter_trigger_o,
	input wire                   delay_pulse_o,
	input wire [5:0]             current_trim_o,
	input wire [1:0]             current_range_o
);
	reg  [15:0] ctrl_q;
	reg  [15:0] curr_q;
	wire        run_w;
	assign run_w = ctrl_q[15] & ~(ctrl_q[13] & idle_i);
	// shadow of written control and current words; edge word is not shadowed, hardware moves its flags
	always @(posedge mclk_i) begin
		if (reset_i) begin
			ctrl_q <= 16'h0000;
			curr_q <= 16'h0000;
		end else if (wr_i && addr_i == `CHARGE_TIME_UNIT_ADDR_CTRL) begin
			ctrl_q <= wdata_i & `CHARGE_TIME_UNIT_CTRL_MASK;
		end else if (wr_i && addr_i == `CHARGE_TIME_UNIT_ADDR_CURR) begin
			curr_q <= wdata_i & `CHARGE_TIME_UNIT_CURR_MASK;
		end
	end
	default clocking @(posedge mclk_i); endclocking
	default disable iff (reset_i);
	property p_rd_quiet; !rd_i |=> rdata_o == 16'h0000; endproperty
	a_rd_quiet: assert property (p_rd_quiet) else $error("read data not zero");
	property p_unmap; rd_i && addr_i == 2'h3 |=> rdata_o == 16'h0000; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
	property p_ctrl_rd; rd_i && addr_i == `CHARGE_TIME_UNIT_ADDR_CTRL |=> rdata_o == ctrl_q; endproperty
	a_ctrl_rd: assert property (p_ctrl_rd) else $error("control readback wrong");
	property p_disch; $stable(ctrl_q) && $stable(idle_i) |-> source_discharge_o == (run_w & ctrl_q[9]); endproperty
	a_disch: assert property (p_disch) else $error("discharge output wrong");
	property p_trim; $stable(curr_q) |-> current_trim_o == curr_q[15:10] && current_range_o == curr_q[9:8]; endproperty
	a_trim: assert property (p_trim) else $error("trim or range output wrong");
	property p_off; !ctrl_q[15] && !$past(ctrl_q[15]) |-> !(source_on_o | source_discharge_o | converter_trigger_o | delay_pulse_o); endproperty
	a_off: assert property (p_off) else $error("disabled unit drives outputs");
	property p_idle; ctrl_q[13] && idle_i && $past(idle_i) && $past(ctrl_q[13]) |-> !source_on_o && !source_discharge_o; endproperty
	a_idle: assert property (p_idle) else $error("unit runs in idle");
	property p_trig_one; converter_trigger_o |=> !converter_trigger_o; endproperty
	a_trig_one: assert property (p_trig_one) else $error("trigger longer than a cycle");
	property p_trig_en; converter_trigger_o |-> $past(ctrl_q[8]); endproperty
	a_trig_en: assert property (p_trig_en) else $error("trigger while disabled");
	property p_delay; delay_pulse_o |-> ctrl_q[12] || $past(ctrl_q[12]); endproperty
	a_delay: assert property (p_delay) else $error("delay without enable");
endmodule // ctec_chk
bind ctec_top ctec_chk i_ctec_chk (.mclk_i, .reset_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .idle_i,
	.source_on_o, .source_discharge_o, .converter_trigger_o, .delay_pulse_o, .current_trim_o, .current_range_o);

/* File: verif/ctec_tb_top.sv */
// self-checking bench of the charge time unit
`timescale 1ns/100ps
`include "charge_time_unit_defines.vh"
module charge_time_edge_control_tb_top;
	logic        mclk_i = 1'b0;
	logic        reset_i = 1'b1;
	logic [1:0]  addr_i = 2'h0;
	logic [15:0] wdata_i = 16'h0000;
	logic        wr_i = 1'b0;
	logic        rd_i = 1'b0;
	logic        idle_i = 1'b0;
	logic [5:0]  want = 6'h00;
	wire  [5:0]  lvl;
	wire  [15:0] rdata_o;
	wire  [5:0]  current_trim_o;
	wire  [1:0]  current_range_o;
	wire         source_on_o;
	wire         source_discharge_o;
	wire         converter_trigger_o;
	wire         delay_pulse_o;
	int          n_fail = 0;
	int          samples_checked = 0;
	int          i;
	int          k;
	logic [15:0] d;
	logic [1:0]  a;
	ctec_src_model i_ctec_src_model (.mclk_i, .want_i(want), .lvl_o(lvl));
	ctec_top i_ctec_top (.mclk_i, .reset_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .idle_i,
		.timer_one_i(lvl[0]), .compare_unit_one_i(lvl[1]), .capture_unit_one_i(lvl[2]), .comparator_one_i(lvl[3]),
		.edge_pin_one_i(lvl[4]), .edge_pin_two_i(lvl[5]), .source_on_o, .source_discharge_o,
		.converter_trigger_o, .delay_pulse_o, .current_trim_o, .current_range_o);
	initial forever #10 mclk_i = ~mclk_i;
	task automatic chk(input [15:0] got, input [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input [1:0] ad, input [15:0] dat);
		@(posedge mclk_i);
		addr_i <= ad;
		wdata_i <= dat;
		wr_i <= 1'b1;
		@(posedge mclk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input [1:0] ad, input [15:0] exp);
		@(posedge mclk_i);
		addr_i <= ad;
		rd_i <= 1'b1;
		@(posedge mclk_i);
		rd_i <= 1'b0;
		#1 chk(rdata_o, exp);
	endtask
	function automatic [15:0] masked(input [1:0] ad, input [15:0] dat);
		masked = ad == 2'h0 ? dat & `CHARGE_TIME_UNIT_CTRL_MASK : ad == 2'h1 ? dat & `CHARGE_TIME_UNIT_EDGE_MASK :
			ad == 2'h2 ? dat & `CHARGE_TIME_UNIT_CURR_MASK : 16'h0000;
	endfunction
	// source index into lvl, 8 for a reserved code
	function automatic [3:0] src_idx(input ch, input [3:0] c);
		case ({ch, c})
			5'h00: src_idx = 4'd0;
			5'h01, 5'h11: src_idx = 4'd1;
			5'h02, 5'h13: src_idx = 4'd5;
			5'h03, 5'h12: src_idx = 4'd4;
			5'h10: src_idx = 4'd2;
			5'h14: src_idx = 4'd3;
			default: src_idx = 4'd8;
		endcase
	endfunction
	// reserved codes get every source toggled, yet must never set a flag
	task automatic src_try(input ch, input [3:0] c, input m, input p);
		logic [15:0] e;
		logic [3:0]  x;
		e = ch ? {2'b00, 4'hf, 2'b00, m, p, c, 2'b00} : {m, p, c, 2'b00, 2'b00, 4'hf, 2'b00};
		x = src_idx(ch, c);
		want <= {6{~p}};
		wr(0, 16'h0000);
		wr(1, e);
		wr(0, 16'h8800);
		repeat (4) @(posedge mclk_i);
		want <= {6{~p}} ^ (x == 4'd8 ? 6'h3f : 6'h01 << x);
		repeat (4) @(posedge mclk_i);
		rd(1, e | (x == 4'd8 ? 16'h0000 : ch ? 16'h0200 : 16'h0100));
	endtask
	task end_of_test;
		$display("mismatches %0d comparisons %0d", n_fail, samples_checked);
		if (n_fail == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		#1500000 n_fail++;
		end_of_test;
	end
	initial begin
		k = $urandom(32'hed30);
		repeat (3) @(posedge mclk_i);
		reset_i <= 1'b0;
		for (i = 0; i < 4; i++) rd(i, 16'h0000);
		// hardware edges held off so the flags belong to software
		for (i = 0; i < 24; i++) begin
			a = $urandom % 4;
			d = $urandom & 16'hf7ff;
			wr(a, d);
			rd(a, masked(a, d));
			// no temperature diode on this bench, so every range code is allowed
			if (a == 2'h2) chk({8'h00, current_trim_o, current_range_o}, {8'h00, d[15:8]});
		end
		for (i = 0; i < 11; i++) src_try(i > 4, i > 4 ? i - 5 : i, $urandom, $urandom);
		want <= 6'h00;
		wr(0, 16'h0000);
		wr(1, {2'b11, 4'h3, 2'b00, 2'b01, 4'h3, 2'b00});
		wr(0, 16'h9d00);
		want <= 6'h20;
		repeat (4) @(posedge mclk_i);
		rd(1, 16'hcc4c);
		chk(source_on_o, 16'h0);
		want <= 6'h10;
		repeat (4) @(posedge mclk_i);
		rd(1, 16'hcd4c);
		chk(delay_pulse_o, 16'h1);
		chk(source_on_o, 16'h1);
		want <= 6'h30;
		k = 0;
		while (converter_trigger_o !== 1'b1 && k < 10) begin
			@(posedge mclk_i);
			#1 k++;
		end
		chk(k < 10, 16'h1);
		rd(1, 16'hcf4c);
		chk({converter_trigger_o, delay_pulse_o, source_on_o}, 16'h0);
		// discharge is set after the measurement, idle gating seen with it
		for (i = 0; i < 4; i++) begin
			d = i < 2 ? 16'ha200 : i == 2 ? 16'h8200 : 16'h0200;
			wr(0, d);
			idle_i <= i != 1;
			repeat (3) @(posedge mclk_i);
			#1 chk(source_discharge_o, d[15] & d[9] & ~(d[13] & (i != 1)));
		end
		end_of_test;
	end
endmodule // charge_time_edge_control_tb_top
